// *** logic/flash_guard_device.sv ***
/*
 * Device end: sector protection, reset-flash handling, reset pin abort
 * and select priority. Array contents are a small register model.
 * Assumes decode selects, supply compare and reset pin come from outside
 * the clock domain and are synchronised here.
 */
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module flash_guard_device (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Bus
	flash_bus_if.device bus,
	// Protection bits from the test port
	input wire logic [7:0] primary_protect_in,
	input wire logic [3:0] secondary_protect_in,
	input wire logic security_lock_in,
	// Decode selects from the address decode array
	input wire logic [7:0] primary_sector_selects_in,
	input wire logic [3:0] secondary_sector_selects_in,
	input wire logic sram_select_in,
	input wire logic io_select_in,
	input wire logic pio_select_in,
	// Power
	input wire logic supply_below_battery_in,
	input wire logic battery_ind_enable_in,
	// Outputs
	output logic [2:0] target_out,
	output logic sram_enable_out,
	output logic battery_on_indicator_out,
	output logic [7:0] erase_done_out
);
	import flash_guard_pkg::*;

	logic [14:0] sel_s1, sel_s2;
	logic [1:0] pwr_s1, pwr_s2;
	logic rst_s1, rst_s2;
	logic [7:0] prot_p1, prot_s1, prot_p, prot_s;
	flash_state_t state_r;
	logic [15:0] tmr_r;
	logic [7:0] mem_r [0:11];
	logic [3:0] op_sec_r;
	logic err_r;
	target_t tgt_nxt;

	// ****************************************
	// Synchronisers
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			sel_s1 <= '0;
			sel_s2 <= '0;
			pwr_s1 <= '0;
			pwr_s2 <= '0;
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
			prot_p1 <= 8'h00;
			prot_s1 <= 8'h00;
			prot_p <= 8'h00;
			prot_s <= 8'h00;
		end
		else
		begin
			sel_s1 <= {sram_select_in, io_select_in, pio_select_in,
				secondary_sector_selects_in, primary_sector_selects_in};
			sel_s2 <= sel_s1;
			pwr_s1 <= {supply_below_battery_in, battery_ind_enable_in};
			pwr_s2 <= pwr_s1;
			rst_s1 <= bus.reset_pin_n;
			rst_s2 <= rst_s1;
			prot_p1 <= primary_protect_in;
			prot_s1 <= {security_lock_in, 3'b000, secondary_protect_in};
			prot_p <= prot_p1;
			prot_s <= prot_s1;
		end

	// ****************************************
	// Select priority
	// ****************************************
	always_comb
	begin
		tgt_nxt = TGT_NONE;
		if (sel_s2[14])
			tgt_nxt = TGT_SRAM;
		else if (sel_s2[13])
			tgt_nxt = TGT_IO;
		else if (sel_s2[12])
			tgt_nxt = TGT_PIO;
		else if (|sel_s2[11:8])
			tgt_nxt = TGT_SECONDARY;
		else if (|sel_s2[7:0])
			tgt_nxt = TGT_PRIMARY;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			target_out <= TGT_NONE;
			sram_enable_out <= 1'b0;
			battery_on_indicator_out <= 1'b0;
		end
		else
		begin
			target_out <= tgt_nxt;
			sram_enable_out <= (tgt_nxt == TGT_SRAM);
			battery_on_indicator_out <= pwr_s2[0] & pwr_s2[1];
		end

	// ****************************************
	// Command state machine
	// ****************************************
	function automatic logic sec_locked(input logic [3:0] s);
		sec_locked = s[3] ? prot_s[s[1:0]] : prot_p[s[2:0]];
	endfunction : sec_locked

	// Sector index: address bits 14:12 pick primary 0-7; bit 15 secondary.
	wire logic [3:0] bus_sec = {bus.addr[15], bus.addr[14:12]};
	wire logic [3:0] mem_idx = bus_sec[3] ? {2'b10, bus_sec[1:0]} :
		{1'b0, bus_sec[2:0]};

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			state_r <= ST_READ;
			tmr_r <= '0;
			op_sec_r <= '0;
			err_r <= 1'b0;
			erase_done_out <= 8'h00;
			for (int i = 0; i < 12; i++)
				mem_r[i] <= 8'hFF;
		end
		else if (!rst_s2)
		begin
			// Pin reset aborts any cycle. The recovery count runs while the
			// pin is low, so a pulse of the recovery time leaves read mode.
			if (state_r != ST_READ && state_r != ST_RECOVER)
				tmr_r <= 16'(RECOVER_CYC);
			else if (tmr_r > 16'd1)
				tmr_r <= tmr_r - 16'd1;
			state_r <= (state_r == ST_RECOVER && tmr_r <= 16'd1) ? ST_READ :
				(state_r == ST_READ) ? ST_READ : ST_RECOVER;
			err_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_READ, ST_UNLOCK1, ST_UNLOCK2:
					if (bus.wr_stb)
					begin
						if (bus.wdata == CMD_RESET_FLASH)
							state_r <= ST_READ;
						else if (state_r == ST_READ &&
							bus.addr[11:0] == UNLOCK1_ADDR &&
							bus.wdata == UNLOCK1_DATA)
							state_r <= ST_UNLOCK1;
						else if (state_r == ST_UNLOCK1 &&
							bus.addr[11:0] == UNLOCK2_ADDR &&
							bus.wdata == UNLOCK2_DATA)
							state_r <= ST_UNLOCK2;
						else if (state_r == ST_UNLOCK2 && sec_locked(bus_sec))
							state_r <= ST_READ;
						else if (state_r == ST_UNLOCK2)
						begin
							op_sec_r <= mem_idx;
							tmr_r <= 16'(OP_TIMEOUT_CYC);
							if (bus.wdata == CMD_SECTOR_ERASE)
								state_r <= ST_SECTOR;
							else if (bus.wdata == CMD_BULK_ERASE)
								state_r <= ST_BULK;
							else if (bus.wdata == CMD_PROGRAM)
								state_r <= ST_PROGRAM;
							else
								state_r <= ST_READ;
						end
						else
							state_r <= ST_READ;
					end
				ST_PROGRAM:
					// The next write carries the data; reset-flash is ignored.
					if (bus.wr_stb)
					begin
						if ((bus.wdata & ~mem_r[op_sec_r]) != 8'h00)
						begin
							err_r <= 1'b1;
							state_r <= ST_ERROR;
						end
						else
						begin
							mem_r[op_sec_r] <= bus.wdata;
							state_r <= ST_READ;
						end
					end
				ST_BULK:
					if (tmr_r == 16'd0)
					begin
						for (int i = 0; i < 12; i++)
							if (!sec_locked(i < 8 ? 4'(i) : 4'(i)))
								mem_r[i] <= 8'hFF;
						erase_done_out <= erase_done_out | ~prot_p;
						state_r <= ST_READ;
					end
					else
						tmr_r <= tmr_r - 16'd1;
				ST_SECTOR:
					if (bus.wr_stb && bus.wdata == CMD_RESET_FLASH)
					begin
						tmr_r <= 16'(RECOVER_CYC);
						state_r <= ST_RECOVER;
					end
					else if (tmr_r == 16'd0)
					begin
						mem_r[op_sec_r] <= 8'hFF;
						// Done flags are sticky and cover primary sectors only.
						if (!op_sec_r[3])
							erase_done_out[op_sec_r[2:0]] <= 1'b1;
						state_r <= ST_READ;
					end
					else
						tmr_r <= tmr_r - 16'd1;
				ST_ERROR:
					if (bus.wr_stb && bus.wdata == CMD_RESET_FLASH)
					begin
						err_r <= 1'b0;
						tmr_r <= 16'(RECOVER_CYC);
						state_r <= ST_RECOVER;
					end
				ST_RECOVER:
					if (tmr_r <= 16'd1)
						state_r <= ST_READ;
					else
						tmr_r <= tmr_r - 16'd1;
				default:
					state_r <= ST_READ;
			endcase
		end

	// ****************************************
	// Bus outputs
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			bus.rdata <= 8'h00;
			bus.busy <= 1'b0;
			bus.error_flag_bit <= 1'b0;
			bus.primary_lock <= 8'h00;
			bus.secondary_lock <= 8'h00;
		end
		else
		begin
			// Reads of a protected sector return stored data as verify.
			bus.rdata <= mem_r[mem_idx];
			bus.busy <= (state_r == ST_PROGRAM) || (state_r == ST_BULK) ||
				(state_r == ST_SECTOR) || (state_r == ST_RECOVER);
			bus.error_flag_bit <= err_r;
			bus.primary_lock <= prot_p;
			bus.secondary_lock <= prot_s & ~STATUS_UNUSED_MASK;
		end
endmodule : flash_guard_device
`default_nettype wire

// *** logic/flash_guard_pkg.sv ***
/*
 * Constants shared by the flash guard device end and the controller end:
 * unlock and command codes, status register field positions, select
 * encodings and the recovery time after a reset or an abort.
 * Assumes a single 25 MHz system clock on both ends.
 */
package flash_guard_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int RECOVER_US = 25;
	localparam int RECOVER_CYC = RECOVER_US * (CLK_HZ / 1000000);
	localparam int OP_TIMEOUT_CYC = 64;
	localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
	localparam logic [11:0] UNLOCK2_ADDR = 12'hAAA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_RESET_FLASH = 8'hF0;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
	localparam logic [7:0] CMD_READ_STATUS = 8'h90;
	localparam int SEC_LOCK_BIT = 7;
	localparam int ERROR_FLAG_BIT = 5;
	localparam logic [7:0] STATUS_UNUSED_MASK = 8'h70;
	// Controller register map (Wishbone byte offsets).
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_PRIM_LOCK = 4'hC;
	localparam logic [7:0] CMD_FIELD_GO = 8'h01;
	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_SRAM = 3'b001,
		TGT_IO = 3'b010,
		TGT_PIO = 3'b011,
		TGT_SECONDARY = 3'b100,
		TGT_PRIMARY = 3'b101
	} target_t;
	typedef enum logic [2:0] {
		ST_READ = 3'b000,
		ST_UNLOCK1 = 3'b001,
		ST_UNLOCK2 = 3'b010,
		ST_PROGRAM = 3'b011,
		ST_BULK = 3'b100,
		ST_SECTOR = 3'b101,
		ST_ERROR = 3'b110,
		ST_RECOVER = 3'b111
	} flash_state_t;
endpackage : flash_guard_pkg

// *** logic/flash_bus_if.sv ***
/*
 * Non-multiplexed 8-bit memory bus joining controller and device end.
 * Assumes both ends share clk_sys_in; write strobe is a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none
interface flash_bus_if;
	logic wr_stb;
	logic rd_stb;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic busy;
	logic error_flag_bit;
	logic [7:0] primary_lock;
	logic [7:0] secondary_lock;
	logic reset_pin_n;
	modport device (input wr_stb, rd_stb, addr, wdata, reset_pin_n,
		output rdata, busy, error_flag_bit, primary_lock, secondary_lock);
	modport controller (output wr_stb, rd_stb, addr, wdata, reset_pin_n,
		input rdata, busy, error_flag_bit, primary_lock, secondary_lock);
endinterface : flash_bus_if
`default_nettype wire

// *** logic/flash_guard_controller.sv ***
/*
 * Controller end: a Wishbone classic slave that turns software requests
 * into bus writes, and shows status and protection bits.
 * Assumes the device end shares clk_sys_in.
 */
`timescale 1ns/1ns
`default_nettype none
module flash_guard_controller (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Bus to the device
	flash_bus_if.controller bus
);
	import flash_guard_pkg::*;

	logic [15:0] addr_r;
	logic [7:0] data_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= '0;
			addr_r <= '0;
			data_r <= '0;
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= '0;
			bus.reset_pin_n <= 1'b1;
		end
		else
		begin
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			wb_ack_out <= 1'b0;
			if (wb_cyc_in && wb_stb_in && !wb_ack_out)
			begin
				wb_ack_out <= 1'b1;
				wb_dat_out <= '0;
				if (wb_we_in && wb_sel_in[0])
					case (wb_adr_in)
						REG_CMD:
						begin
							// Bit 0 issues a write, bit 1 drives the reset pin.
							bus.wr_stb <= wb_dat_in[0];
							bus.addr <= addr_r;
							bus.wdata <= data_r;
							bus.reset_pin_n <= ~wb_dat_in[1];
						end
						REG_ADDR:
						begin
							addr_r <= wb_dat_in[15:0];
							data_r <= wb_dat_in[23:16];
						end
						default:
							addr_r <= addr_r;
					endcase
				else if (!wb_we_in)
					case (wb_adr_in)
						REG_STATUS:
							wb_dat_out <= {16'h0000, bus.rdata, 5'b00000,
								~bus.reset_pin_n, bus.error_flag_bit, bus.busy};
						REG_PRIM_LOCK:
							wb_dat_out <= {16'h0000, bus.secondary_lock,
								bus.primary_lock};
						REG_ADDR:
							wb_dat_out <= {8'h00, data_r, addr_r};
						default:
							wb_dat_out <= '0;
					endcase
			end
		end
endmodule : flash_guard_controller
`default_nettype wire

// *** tb/flash_guard_chk.sv ***
/* Checker on the flash bus that joins the controller and device ends.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module flash_guard_chk (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Bus signals
	input wire logic wr_stb,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic busy,
	input wire logic error_flag_bit,
	input wire logic [7:0] primary_lock,
	input wire logic [7:0] secondary_lock,
	input wire logic reset_pin_n
);
	import flash_guard_pkg::*;
	// Recovery plus the longest timed operation, with a little slack.
	localparam int LIMIT = 700;
	logic [10:0] busy_cnt_r;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_reset_flash;
		wr_stb && wdata == CMD_RESET_FLASH;
	endsequence
	sequence s_quiet;
		!busy && !error_flag_bit;
	endsequence
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			busy_cnt_r <= 11'h000;
		else if (busy)
			busy_cnt_r <= busy_cnt_r + 11'h001;
		else
			busy_cnt_r <= 11'h000;
	end
	a_unused_zero: assert property (secondary_lock[6:4] == 3'b000)
		else $error("unused secondary status bits set");
	a_lock_unwritable: assert property (
		wr_stb |=> $stable({primary_lock, secondary_lock}) [*3])
		else $error("bus write changed protection status");
	a_protect_ignore: assert property (
		wr_stb && wdata == CMD_SECTOR_ERASE && !addr[15] && !busy &&
		primary_lock[addr[14:12]] |=> !busy [*4])
		else $error("erase started on a protected sector");
	a_abort_erase: assert property (
		s_reset_flash ##0 busy |-> ##[1:LIMIT] !busy)
		else $error("reset-flash did not end the operation in time");
	a_error_recover: assert property (
		s_reset_flash ##0 error_flag_bit |-> ##[1:LIMIT] s_quiet)
		else $error("reset-flash did not clear the error in time");
	// The flag clears a few edges after the command or the pin, so the
	// recent past of both is left out of the antecedent.
	a_error_holds: assert property (
		error_flag_bit && !(wr_stb && wdata == CMD_RESET_FLASH) &&
		!($past(wr_stb) && $past(wdata) == CMD_RESET_FLASH) &&
		reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2) &&
		$past(reset_pin_n, 3) |=> error_flag_bit)
		else $error("error flag dropped without reset-flash");
	a_pin_abort: assert property (
		$rose(reset_pin_n) |-> ##[0:LIMIT] s_quiet)
		else $error("reset pin did not restore read mode in time");
	a_busy_bounded: assert property (busy_cnt_r < 11'h2D0)
		else $error("busy held beyond the recovery bound");
endmodule : flash_guard_chk
`default_nettype wire

// *** tb/tb.sv ***
/* Bench joining controller and device ends over the flash bus.
   Assumes the package and interface are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import flash_guard_pkg::*;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [3:0] wb_sel_in = 4'h0;
	logic [3:0] wb_adr_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h0;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic [7:0] primary_protect_in = 8'h00;
	logic [3:0] secondary_protect_in = 4'h0;
	logic security_lock_in = 1'b0;
	logic [7:0] primary_sector_selects_in = 8'h00;
	logic [3:0] secondary_sector_selects_in = 4'h0;
	logic sram_select_in = 1'b0;
	logic io_select_in = 1'b0;
	logic pio_select_in = 1'b0;
	logic supply_below_battery_in = 1'b0;
	logic battery_ind_enable_in = 1'b0;
	logic [2:0] target_out;
	logic sram_enable_out;
	logic battery_on_indicator_out;
	logic [7:0] erase_done_out;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	logic [31:0] q;
	logic [31:0] lk;
	logic [8:0] r;
	target_t t;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	flash_bus_if bus_if();
	flash_guard_device u_flash_guard_device (.clk_sys_in, .reset_n_in,
		.bus(bus_if), .primary_protect_in, .secondary_protect_in,
		.security_lock_in, .primary_sector_selects_in,
		.secondary_sector_selects_in, .sram_select_in, .io_select_in,
		.pio_select_in, .supply_below_battery_in, .battery_ind_enable_in,
		.target_out, .sram_enable_out, .battery_on_indicator_out,
		.erase_done_out);
	flash_guard_controller u_flash_guard_controller (.clk_sys_in,
		.reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
		.wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.bus(bus_if));
	flash_guard_chk u_flash_guard_chk (.clk_sys_in, .reset_n_in,
		.wr_stb(bus_if.wr_stb), .addr(bus_if.addr), .wdata(bus_if.wdata),
		.busy(bus_if.busy), .error_flag_bit(bus_if.error_flag_bit),
		.primary_lock(bus_if.primary_lock),
		.secondary_lock(bus_if.secondary_lock),
		.reset_pin_n(bus_if.reset_pin_n));
	always #20 clk_sys_in = ~clk_sys_in;
	// ****
	// Bus tasks and comparison
	// ****
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x)
			begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, s, x);
		end
	endtask : check
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_sel_in <= 4'hF;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do
			@(posedge clk_sys_in);
		while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb
	// A zero mask notes a read whose value is only polled, not judged.
	task automatic rd(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] x);
		exp_q.push_back({m, x});
		wb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
		wb(REG_ADDR, 1'b1, {8'h00, d, a});
		wb(REG_CMD, 1'b1, 32'h1);
	endtask : dev_wr
	task automatic cmd(input logic [15:0] a, input logic [7:0] c);
		dev_wr({4'h0, UNLOCK1_ADDR}, UNLOCK1_DATA);
		dev_wr({4'h0, UNLOCK2_ADDR}, UNLOCK2_DATA);
		dev_wr(a, c);
	endtask : cmd
	task automatic quiet(input logic [31:0] m);
		time t0;
		t0 = $time;
		do
			rd(REG_STATUS, 32'h0, 32'h0);
		while ((q & m) !== 32'h0);
		n = int'(($time - t0) / 40);
	endtask : quiet
	task automatic close_out();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	always @(posedge clk_sys_in)
		if (wb_ack_out === 1'b1 && wb_we_in === 1'b0)
		begin
			e = exp_q.pop_front();
			if (e[63:32] != 32'h0)
				check(wb_dat_out & e[63:32], e[31:0]);
		end
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		err_total++;
		close_out();
	end
	// ****
	// Test sequence
	// ****
	initial
	begin
		void'($urandom(34));
		repeat (8) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		rd(4'h2, 32'hFFFFFFFF, 32'h0);
		rd(REG_STATUS, 32'h7, 32'h0);
		repeat (4)
		begin
			lk = {16'h0, 1'($urandom()), 3'b000, 4'($urandom()), 8'($urandom())};
			primary_protect_in <= lk[7:0];
			secondary_protect_in <= lk[11:8];
			security_lock_in <= lk[15];
			repeat (6) @(posedge clk_sys_in);
			wb(REG_PRIM_LOCK, 1'b1, ~lk);
			rd(REG_PRIM_LOCK, 32'hFFFF, lk);
		end
		$display("done: status registers");
		primary_protect_in <= 8'hFF;
		repeat (6) @(posedge clk_sys_in);
		cmd(16'h3000, CMD_SECTOR_ERASE);
		rd(REG_STATUS, 32'h3, 32'h0);
		primary_protect_in <= 8'h00;
		repeat (6) @(posedge clk_sys_in);
		cmd(16'h3000, CMD_SECTOR_ERASE);
		rd(REG_STATUS, 32'h1, 32'h1);
		dev_wr(16'h3000, CMD_RESET_FLASH);
		quiet(32'h3);
		check(32'(n <= RECOVER_CYC + 40), 32'h1);
		check(32'(erase_done_out[3]), 32'h0);
		$display("done: protect and abort");
		cmd(16'h5000, CMD_SECTOR_ERASE);
		quiet(32'h1);
		check(32'(erase_done_out[5]), 32'h1);
		cmd(16'h5000, CMD_PROGRAM);
		dev_wr(16'h5000, 8'h00);
		quiet(32'h1);
		rd(REG_STATUS, 32'h2, 32'h0);
		cmd(16'h5000, CMD_PROGRAM);
		dev_wr(16'h5000, 8'hFF);
		quiet(32'h1);
		rd(REG_STATUS, 32'h2, 32'h2);
		cmd(16'h0000, CMD_RESET_FLASH);
		quiet(32'h3);
		check(32'(n <= RECOVER_CYC + 40), 32'h1);
		$display("done: error flag");
		primary_protect_in <= 8'h20;
		repeat (6) @(posedge clk_sys_in);
		cmd(16'h5000, CMD_SECTOR_ERASE);
		rd(REG_STATUS, 32'hFF07, 32'h0);
		primary_protect_in <= 8'h00;
		repeat (6) @(posedge clk_sys_in);
		$display("done: protected verify");
		cmd(16'h6000, CMD_SECTOR_ERASE);
		wb(REG_CMD, 1'b1, 32'h2);
		rd(REG_STATUS, 32'h4, 32'h4);
		repeat (RECOVER_CYC) @(posedge clk_sys_in);
		wb(REG_CMD, 1'b1, 32'h0);
		quiet(32'h3);
		check(32'(n <= RECOVER_CYC + 40), 32'h1);
		check(32'(erase_done_out[6]), 32'h0);
		$display("done: reset pin");
		primary_protect_in <= 8'h40;
		repeat (6) @(posedge clk_sys_in);
		cmd(16'h0000, CMD_BULK_ERASE);
		dev_wr(16'h0000, CMD_RESET_FLASH);
		quiet(32'h3);
		check(32'(n < 200), 32'h1);
		check(32'(erase_done_out), 32'hBF);
		primary_protect_in <= 8'h00;
		$display("done: bulk erase");
		repeat (24)
		begin
			r = 9'($urandom());
			t = r[8:7] != 2'b00 ? target_t'({1'b0, r[8:7]}) :
				r[6] ? TGT_SECONDARY : r[3] ? TGT_PRIMARY : TGT_NONE;
			@(posedge clk_sys_in);
			primary_sector_selects_in <= r[3] ? 8'h01 << r[2:0] : 8'h00;
			secondary_sector_selects_in <= r[6] ? 4'h1 << r[5:4] : 4'h0;
			sram_select_in <= r[8:7] == 2'b01;
			io_select_in <= r[8:7] == 2'b10;
			pio_select_in <= r[8:7] == 2'b11;
			repeat (4) @(posedge clk_sys_in);
			#1;
			check(32'(target_out), 32'(t));
			check(32'(sram_enable_out), 32'(t == TGT_SRAM));
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys_in);
			supply_below_battery_in <= i[0];
			battery_ind_enable_in <= i[1];
			repeat (4) @(posedge clk_sys_in);
			#1;
			check(32'(battery_on_indicator_out), 32'(i[0] & i[1]));
		end
		$display("done: selects and battery");
		close_out();
	end
endmodule : tb
`default_nettype wire
